// *** dv/adc_host_model.sv ***
// host model driving the serial clock and channel select lines
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
  // clock
  input  wire logic i_clk_sys,
  // pins
  input  wire logic i_serial_data_out,
  output var  logic o_serial_clk,
  output var  logic o_sel_low,
  output var  logic o_sel_high
);
  initial begin
    o_serial_clk = 1'b1;
    o_sel_low    = 1'b0;
    o_sel_high   = 1'b0;
  end
  // low four cycles, high hi cycles; samples two negedges after the rise and at the end
  task automatic pulse(input int hi, output logic b, output logic c);
    @(posedge i_clk_sys) o_serial_clk <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    o_serial_clk <= 1'b1;
    repeat (2) @(negedge i_clk_sys);
    b = i_serial_data_out;
    repeat (hi - 2) @(negedge i_clk_sys);
    c = i_serial_data_out;
  endtask
  // select held past the start edge, then scrambled
  task automatic start(input logic [1:0] ch, output logic b, output logic c);
    @(posedge i_clk_sys) {o_sel_high, o_sel_low} <= ch;
    pulse(8, b, c);
    @(posedge i_clk_sys) {o_sel_high, o_sel_low} <= ~ch;
  endtask
  // one-cycle low pulse, below filter width
  task automatic glitch;
    @(posedge i_clk_sys) o_serial_clk <= 1'b0;
    @(posedge i_clk_sys) o_serial_clk <= 1'b1;
  endtask
  // toggle clock until start pattern seen
  task automatic resync(output int n);
    logic a, b, c;
    bit found;
    found = 1'b0;
    n = 0;
    while (!found && n < 40) begin
      a = i_serial_data_out;
      pulse(8, b, c);
      n++;
      found = a && b && !c;
    end
  endtask
endmodule
`default_nettype wire

// *** dv/adc_port_properties.sv ***
// assertion checker for the two-wire convert and read port
`timescale 1ns/1ps
`default_nettype none
module adc_port_properties #(
  parameter integer WINDOW_CYC = 100
) (
  // clock, reset and host pin
  input wire logic       i_clk_sys,
  input wire logic       i_sys_rst,
  input wire logic       i_serial_clk,
  // watched outputs and result valid input
  input wire logic       o_serial_data_out,
  input wire logic       o_osc_enable,
  input wire logic [1:0] o_channel_sel,
  input wire logic       o_conv_start,
  input wire logic [4:0] o_conv_bits,
  input wire logic       i_result_valid,
  input wire logic       o_result_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  localparam int WLO = WINDOW_CYC - 3;
  localparam int WHI = WINDOW_CYC + 4;

  AST_RST_IDLE: assert property ($fell(i_sys_rst) |-> o_serial_data_out && !o_osc_enable)
    else $error("port not idle after reset");
  AST_BITS_RANGE: assert property (o_conv_bits >= 5'hA && o_conv_bits <= 5'h10)
    else $error("resolution out of range");
  AST_START_HIGH: assert property ($rose(o_osc_enable) |-> o_serial_data_out)
    else $error("data not high at start");
  AST_ONE_PULSE: assert property (o_conv_start |=> !o_conv_start)
    else $error("conversion start longer than one cycle");
  AST_BUSY_LOW: assert property (o_conv_start |-> o_osc_enable && !o_serial_data_out)
    else $error("data not low at conversion start");
  AST_WINDOW_LEN: assert property ($rose(o_osc_enable) |-> ##[WLO:WHI] o_conv_start)
    else $error("window length wrong");
  AST_BITS_SET: assert property ($changed(o_conv_bits) |-> o_conv_start)
    else $error("resolution changed outside window end");
  AST_SEL_HELD: assert property ($past(o_osc_enable) && o_osc_enable |-> $stable(o_channel_sel))
    else $error("channel changed during conversion");
  AST_SLEEP_DONE: assert property ($fell(o_osc_enable) |-> ##[0:1] o_serial_data_out)
    else $error("data not high on completion");
  AST_ACK_END: assert property ($rose(i_serial_clk) && o_osc_enable |-> ##[1:8] !o_serial_data_out)
    else $error("acknowledge did not end");
  cover property ($rose(o_osc_enable));
  cover property (o_conv_start && o_conv_bits == 5'hA);
  cover property (i_result_valid && !o_result_ready);
endmodule
bind adc_two_wire_convert_read_port adc_port_properties #(.WINDOW_CYC(WINDOW_CYC)) u_props (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_serial_clk(i_serial_clk),
  .o_serial_data_out(o_serial_data_out), .o_osc_enable(o_osc_enable),
  .o_channel_sel(o_channel_sel), .o_conv_start(o_conv_start), .o_conv_bits(o_conv_bits),
  .i_result_valid(i_result_valid), .o_result_ready(o_result_ready));
`default_nettype wire

// *** dv/adc_two_wire_convert_read_port_bench.sv ***
// self-checking bench of the two-wire convert and read port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module adc_two_wire_convert_read_port_bench;
  logic        i_clk_sys = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        rv = 1'b0;
  logic [15:0] rw = 16'h0;
  wire logic   sclk, sel_lo, sel_hi, sdo, osc, cst, rdy;
  wire logic [1:0] sel;
  wire logic [4:0] bits;
  logic [15:0] core_q[$];
  logic [15:0] exp_q[$];
  int          failures = 0;
  int          check_count = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  adc_two_wire_convert_read_port #(.WINDOW_CYC(100)) u_dut (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_serial_clk(sclk),
    .i_channel_select_low(sel_lo), .i_channel_select_high(sel_hi), .o_serial_data_out(sdo),
    .o_osc_enable(osc), .o_channel_sel(sel), .o_conv_start(cst), .o_conv_bits(bits),
    .i_result_valid(rv), .i_result(rw), .o_result_ready(rdy));
  adc_host_model h (.i_clk_sys(i_clk_sys), .i_serial_data_out(sdo), .o_serial_clk(sclk),
    .o_sel_low(sel_lo), .o_sel_high(sel_hi));

  // converter core: offers queued words, holds while refused
  always @(posedge i_clk_sys) begin
    if (rv && rdy) void'(core_q.pop_front());
    rv <= (core_q.size() != 0);
    rw <= (core_q.size() != 0) ? core_q[0] : ~rw;
  end

  task automatic convert(input logic [1:0] ch, input int d, input bit push, input logic [15:0] w);
    logic b, c;
    h.start(ch, b, c);
    `CHK("start ack", 1'b1, b)
    `CHK("start end", 1'b0, c)
    complete(ch, d, push, w);
  endtask

  task automatic complete(input logic [1:0] ch, input int d, input bit push, input logic [15:0] w);
    logic b, c;
    logic [15:0] e, got;
    int acc, n, i;
    acc = (d > 6) ? 6 : d;
    n = 16 - acc;
    for (i = 0; i < d; i++) begin
      h.pulse(6, b, c);
      `CHK("drop ack", (i < 6), b)
      `CHK("drop end", 1'b0, c)
    end
    `CHK("chan", ch, sel)
    for (i = 0; cst !== 1'b1 && i < 300; i++) @(negedge i_clk_sys);
    `CHK("conv start", 1'b1, cst)
    `CHK("bits", 5'(n), bits)
    `CHK("busy", 1'b0, sdo)
    if (push) begin
      core_q.push_back(w);
      exp_q.push_back(w);
    end
    for (i = 0; sdo !== 1'b1 && i < 40; i++) @(negedge i_clk_sys);
    `CHK("done", 1'b1, sdo)
    e = exp_q.pop_front() >> acc;
    if (e == (16'h1 << (n - 1))) e = e | 16'h1;
    got = 16'h0;
    for (i = 0; i < n; i++) begin
      h.pulse(4, b, c);
      got = {got[14:0], c};
    end
    `CHK("word", e, got)
    repeat (6) @(negedge i_clk_sys);
    `CHK("sleep", 1'b1, sdo)
  endtask

  task automatic t_reset;
    @(negedge i_clk_sys);
    `CHK("idle data", 1'b1, sdo)
    `CHK("idle osc", 1'b0, osc)
    `CHK("idle bits", 5'h10, bits)
    $display("test reset done");
  endtask

  task automatic t_channels;
    logic [15:0] wt[4] = '{16'h8000, 16'h7FFF, 16'hA5C3, 16'h8000};
    int dt[4] = '{0, 2, 7, 6};
    for (int k = 0; k < 4; k++) convert(k[1:0], dt[k], 1'b1, wt[k]);
    $display("test channels done");
  endtask

  task automatic t_buffer;
    core_q = '{16'h4321, 16'hFFFF, 16'h8001};
    exp_q = core_q;
    repeat (8) @(negedge i_clk_sys);
    `CHK("full", 1'b0, rdy)
    convert(2'h1, 1, 1'b0, 16'h0);
    convert(2'h2, 3, 1'b0, 16'h0);
    convert(2'h3, 5, 1'b0, 16'h0);
    `CHK("empty", 1'b0, rv)
    $display("test buffer done");
  endtask

  task automatic t_glitch;
    h.glitch();
    repeat (8) @(negedge i_clk_sys);
    `CHK("glitch osc", 1'b0, osc)
    `CHK("glitch data", 1'b1, sdo)
    $display("test glitch done");
  endtask

  task automatic t_resync;
    logic b, c;
    logic [2:0] got;
    int i, n;
    h.start(2'h2, b, c);
    for (i = 0; cst !== 1'b1 && i < 300; i++) @(negedge i_clk_sys);
    core_q.push_back(16'hC3A5);
    for (i = 0; sdo !== 1'b1 && i < 40; i++) @(negedge i_clk_sys);
    got = 3'h0;
    for (i = 0; i < 3; i++) begin
      h.pulse(4, b, c);
      got = {got[1:0], c};
    end
    `CHK("part word", 3'h6, got)
    h.resync(n);
    `CHK("resync pulses", 14, n)
    complete(2'h1, 0, 1'b1, 16'h1234);
    $display("test resync done");
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    failures++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    t_reset();
    t_glitch();
    t_channels();
    t_buffer();
    t_resync();
    final_report();
  end
endmodule
`default_nettype wire

// *** logic/adc_port_consts.vh ***
// constants of the two-wire convert and read port
//
// Behaviour
// - channel select latched on start edge
// - select 00..11 picks inputs one to four
// - idle: sleep, data high, clock high
// - idle falling edge starts conversion, clock
// - window falling edge drops one bit
// - at most six drops, ten bits floor
// - accepted drop acknowledged by data high
// - acknowledge ends on rise or expiry
// - data low while converting
// - completion drives data high, sleeps
// - each falling edge shifts next bit
// - two's complement, sign bit first
// - full result sign plus fifteen bits
// - seventeen falling edges per cycle
// - sign-only code never output
// - clock filter rejects pulses under 50ns
// - data pattern marks state to host
`ifndef ADC_PORT_CONSTS_VH
`define ADC_PORT_CONSTS_VH

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS   100
`define FILTER_NS       50
`define FILTER_CYC      ((`FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WINDOW_US       1459
`define WINDOW_CYC      ((`WINDOW_US * 1000) / `CLK_PERIOD_NS)

// ****************************************
// resolution and result
// ****************************************
`define FULL_BITS       16
`define MIN_BITS        10
`define MAX_DROPS       6
`define SIGN_ONLY       16'h8000

// ****************************************
// channel codes
// ****************************************
`define CHAN_IN1        2'h0
`define CHAN_IN2        2'h1
`define CHAN_IN3        2'h2
`define CHAN_IN4        2'h3

`endif

// *** logic/adc_two_wire_convert_read_port.v ***
// convert and read control of the two-wire converter port
`timescale 1ns/1ps
`default_nettype none
`include "adc_port_consts.vh"

module adc_two_wire_convert_read_port #(
  parameter integer WINDOW_CYC = `WINDOW_CYC,
  parameter integer FILTER_CYC = `FILTER_CYC,
  parameter integer DATA_W     = `FULL_BITS
) (
  // clock and reset
  input  wire              i_clk_sys,
  input  wire              i_sys_rst,
  // host pins
  input  wire              i_serial_clk,
  input  wire              i_channel_select_low,
  input  wire              i_channel_select_high,
  output wire              o_serial_data_out,
  // converter core control
  output wire              o_osc_enable,
  output wire [1:0]        o_channel_sel,
  output wire              o_conv_start,
  output wire [4:0]        o_conv_bits,
  // converter core result
  input  wire              i_result_valid,
  input  wire [DATA_W-1:0] i_result,
  output wire              o_result_ready
);

  localparam [2:0] ST_SLEEP  = 3'h0;
  localparam [2:0] ST_WINDOW = 3'h1;
  localparam [2:0] ST_BUSY   = 3'h2;
  localparam [2:0] ST_READY  = 3'h3;
  localparam [2:0] ST_SHIFT  = 3'h4;
  localparam [2:0] ST_LAST   = 3'h5;

  localparam integer FULL_I    = `FULL_BITS;
  localparam integer DROPS_I   = `MAX_DROPS;
  localparam integer WIN_I     = WINDOW_CYC - 1;
  localparam integer FILT_I    = FILTER_CYC - 1;
  localparam [4:0]   FULL_BITS = FULL_I[4:0];
  localparam [2:0]   MAX_DROPS = DROPS_I[2:0];
  localparam [23:0]  WIN_LAST  = WIN_I[23:0];
  localparam [7:0]   FILT_LAST = FILT_I[7:0];

  // ****************************************
  // functions
  // ****************************************
  // replace sign-only code at the given resolution
  function [DATA_W-1:0] clamp_code;
    input [DATA_W-1:0] word;
    input [2:0]        drops;
    reg   [DATA_W-1:0] keep;
    begin
      keep = {DATA_W{1'b1}} << drops;
      if ((word & keep) == `SIGN_ONLY)
        clamp_code = `SIGN_ONLY | (({DATA_W{1'b0}} | 1'b1) << drops);
      else
        clamp_code = word & keep;
    end
  endfunction

  // ****************************************
  // clock pin sampling and filter
  // ****************************************
  reg       s1_r;
  reg       s2_r;
  reg       s3_r;
  reg       lvl_r;
  reg       lvl_nxt;
  reg [7:0] filt_r;
  reg [7:0] filt_nxt;
  reg [1:0] sel_s1_r;
  reg [1:0] sel_s2_r;
  reg [1:0] sel_s3_r;
  reg [1:0] sel_lvl_r;

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
    end else begin
      s1_r <= i_serial_clk;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // select pins, taken once two stages agree
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sel_s1_r  <= 2'h0;
      sel_s2_r  <= 2'h0;
      sel_s3_r  <= 2'h0;
      sel_lvl_r <= 2'h0;
    end else begin
      sel_s1_r <= {i_channel_select_high, i_channel_select_low};
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
      if (sel_s2_r == sel_s3_r)
        sel_lvl_r <= sel_s3_r;
    end
  end

  always @* begin
    lvl_nxt  = lvl_r;
    filt_nxt = 8'h00;
    if (s2_r == s3_r && s3_r != lvl_r) begin
      if (filt_r >= FILT_LAST)
        lvl_nxt = s3_r;
      else
        filt_nxt = filt_r + 8'h01;
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      lvl_r  <= 1'b1;
      filt_r <= 8'h00;
    end else begin
      lvl_r  <= lvl_nxt;
      filt_r <= filt_nxt;
    end
  end

  wire fall = lvl_r & ~lvl_nxt;
  wire rise = ~lvl_r & lvl_nxt;

  // ****************************************
  // two-entry result buffer
  // ****************************************
  reg [DATA_W-1:0] buf_mem [0:1];
  reg              wr_ptr_r;
  reg              rd_ptr_r;
  reg [1:0]        cnt_r;
  wire             buf_full  = (cnt_r == 2'h2);
  wire             buf_empty = (cnt_r == 2'h0);
  wire             buf_in_ok;
  wire             buf_out_ok;
  wire [DATA_W-1:0] buf_head = buf_mem[rd_ptr_r];

  always @(posedge i_clk_sys) begin
    if (buf_in_ok)
      buf_mem[wr_ptr_r] <= i_result;
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (buf_in_ok)
        wr_ptr_r <= ~wr_ptr_r;
      if (buf_out_ok)
        rd_ptr_r <= ~rd_ptr_r;
      case ({buf_in_ok, buf_out_ok})
        2'b10:   cnt_r <= cnt_r + 2'h1;
        2'b01:   cnt_r <= cnt_r - 2'h1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // ****************************************
  // sequence control
  // ****************************************
  reg [2:0]        st_r;
  reg [2:0]        st_nxt;
  reg [1:0]        chan_r;
  reg [1:0]        chan_nxt;
  reg [2:0]        drops_r;
  reg [2:0]        drops_nxt;
  reg [23:0]       win_r;
  reg [23:0]       win_nxt;
  reg [4:0]        bits_r;
  reg [4:0]        bits_nxt;
  reg [DATA_W-1:0] sh_r;
  reg [DATA_W-1:0] sh_nxt;
  reg              serial_data_out_r;
  reg              serial_data_out_nxt;
  reg              start_r;
  reg              start_nxt;
  reg [4:0]        conv_bits_r;
  reg [4:0]        conv_bits_nxt;
  reg              pop;
  reg [DATA_W-1:0] word;

  assign buf_in_ok  = i_result_valid & ~buf_full;
  assign buf_out_ok = pop;

  always @* begin
    st_nxt    = st_r;
    chan_nxt  = chan_r;
    drops_nxt = drops_r;
    win_nxt   = win_r;
    bits_nxt  = bits_r;
    sh_nxt    = sh_r;
    serial_data_out_nxt  = serial_data_out_r;
    start_nxt = 1'b0;
    conv_bits_nxt = conv_bits_r;
    pop       = 1'b0;
    word      = clamp_code(buf_head, drops_r);
    case (st_r)
      ST_SLEEP: begin
        serial_data_out_nxt = 1'b1;
        if (fall) begin
          st_nxt    = ST_WINDOW;
          chan_nxt  = sel_lvl_r;
          drops_nxt = 3'h0;
          win_nxt   = 24'h000000;
          serial_data_out_nxt  = 1'b1;
        end
      end
      ST_WINDOW: begin
        win_nxt = win_r + 24'h000001;
        if (rise)
          serial_data_out_nxt = 1'b0;
        if (fall && drops_r < MAX_DROPS) begin
          drops_nxt = drops_r + 3'h1;
          serial_data_out_nxt  = 1'b1;
        end
        if (win_r >= WIN_LAST) begin
          st_nxt    = ST_BUSY;
          serial_data_out_nxt  = 1'b0;
          start_nxt = 1'b1;
          conv_bits_nxt = FULL_BITS - {2'b00, drops_nxt};
        end
      end
      ST_BUSY: begin
        serial_data_out_nxt = 1'b0;
        if (!buf_empty) begin
          st_nxt   = ST_READY;
          serial_data_out_nxt = 1'b1;
        end
      end
      ST_READY: begin
        serial_data_out_nxt = 1'b1;
        if (fall) begin
          pop      = 1'b1;
          serial_data_out_nxt = word[DATA_W-1];
          sh_nxt   = word << 1;
          bits_nxt = FULL_BITS - {2'b00, drops_r} - 5'h1;
          st_nxt   = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (fall) begin
          serial_data_out_nxt = sh_r[DATA_W-1];
          sh_nxt   = sh_r << 1;
          bits_nxt = bits_r - 5'h1;
          if (bits_r == 5'h1)
            st_nxt = ST_LAST;
        end
      end
      ST_LAST: begin
        if (lvl_r) begin
          st_nxt   = ST_SLEEP;
          serial_data_out_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt   = ST_SLEEP;
        serial_data_out_nxt = 1'b1;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_r    <= ST_SLEEP;
      chan_r  <= `CHAN_IN1;
      drops_r <= 3'h0;
      win_r   <= 24'h000000;
      bits_r  <= 5'h00;
      sh_r    <= {DATA_W{1'b0}};
      serial_data_out_r  <= 1'b1;
      start_r <= 1'b0;
      conv_bits_r <= FULL_BITS;
    end else begin
      st_r    <= st_nxt;
      chan_r  <= chan_nxt;
      drops_r <= drops_nxt;
      win_r   <= win_nxt;
      bits_r  <= bits_nxt;
      sh_r    <= sh_nxt;
      serial_data_out_r  <= serial_data_out_nxt;
      start_r <= start_nxt;
      conv_bits_r <= conv_bits_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_serial_data_out = serial_data_out_r;
  assign o_osc_enable      = (st_r == ST_WINDOW) | (st_r == ST_BUSY);
  assign o_channel_sel     = chan_r;
  assign o_conv_start      = start_r;
  assign o_conv_bits       = conv_bits_r;
  assign o_result_ready    = ~buf_full;

endmodule

`default_nettype wire
